// *** ppf_pkg.sv ***
// ppf_pkg: constants, register map and types of the periodic payload framer.
// assumes a 100 MHz hclk; all users write ppf_pkg::name.
package ppf_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SECOND_NS = 1_000_000_000;
  localparam int unsigned CYCLES_PER_SEC = SECOND_NS / CLK_PERIOD_NS;

  localparam logic [16:0] MIN_INTERVAL_S = 17'h0000A;
  localparam logic [16:0] MAX_INTERVAL_S = 17'h15180;
  localparam logic [16:0] SEC_PER_MIN = 17'h0003C;
  localparam logic [16:0] SEC_PER_HOUR = 17'h00E10;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INTERVAL = 8'h04;
  localparam logic [7:0] OFF_TAG = 8'h08;
  localparam logic [7:0] OFF_DEST = 8'h0C;
  localparam logic [7:0] OFF_PIN_MODE = 8'h10;
  localparam logic [7:0] OFF_PIN_CFG = 8'h14;
  localparam logic [7:0] OFF_COUNTER = 8'h18;
  localparam logic [7:0] OFF_CONV_CFG = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_SNAPSHOT = 8'h24;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_APP_LSB = 1;
  localparam int CTRL_UNIT_LSB = 3;
  localparam int CFG_MASK_LSB = 0;
  localparam int CFG_PULL_LSB = 8;
  localparam int CFG_PULLUP_BIT = 16;
  localparam int CFG_DOUT_LSB = 24;
  localparam int CNT_EN_BIT = 3;

  localparam logic [15:0] INTERVAL_RST = 16'h000A;
  localparam logic [7:0] TAG_RST = 8'h00;
  localparam logic [15:0] DEST_RST = 16'h0000;
  localparam logic [15:0] PIN_MODE_RST = 16'h0000;
  localparam logic [31:0] CONV_CFG_RST = 32'h0000_0000;

  localparam logic [3:0] LEN_PINS = 4'hD;
  localparam logic [3:0] LEN_SENSOR = 4'h5;
  localparam logic [7:0] MAX_NEIGH = 8'h05;

  typedef enum logic [1:0] {APP_PINS = 2'h0, APP_SENSOR = 2'h1, APP_NEIGH = 2'h2} ppf_app_e;
  typedef enum logic [1:0] {UNIT_SEC = 2'h0, UNIT_MIN = 2'h1, UNIT_HOUR = 2'h2} ppf_unit_e;
  typedef enum logic [1:0] {PIN_DIN = 2'h0, PIN_DOUT = 2'h1, PIN_AIN = 2'h2} ppf_pin_e;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_FETCH = 2'b01, ST_SEND = 2'b11} ppf_state_e;

endpackage : ppf_pkg

// *** ppf_pin_sampler.sv ***
// ppf_pin_sampler: pin synchronisers, falling-edge mask and edge counter.
// assumes asynchronous pins; clear is a one-cycle pulse from same domain.
`timescale 1ns/100ps
module ppf_pin_sampler (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [7:0] pin_in,
  input wire logic cnt_en,
  input wire logic [2:0] cnt_pin,
  input wire logic clear,
  output logic [7:0] level,
  output logic [7:0] edges,
  output logic [15:0] count
);

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] lvl;
    logic [7:0] edges;
    logic [15:0] count;
  } ppf_smp_s;

  ppf_smp_s r_reg;
  ppf_smp_s r_next;
  logic [7:0] agree;
  logic [7:0] fall;

  always_comb
  begin
    r_next = r_reg;
    r_next.s1 = pin_in;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    agree = ~(r_reg.s2 ^ r_reg.s3);
    r_next.lvl = (agree & r_reg.s2) | (~agree & r_reg.lvl);
    fall = r_reg.lvl & ~r_next.lvl;
    // new edge beats the clear
    r_next.edges = (clear ? 8'h00 : r_reg.edges) | fall;
    if (clear)
    begin
      r_next.count = 16'h0000;
    end
    if (cnt_en && fall[cnt_pin] && r_next.count != 16'hFFFF)
    begin
      r_next.count = r_next.count + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign level = r_reg.lvl;
  assign edges = r_reg.edges;
  assign count = r_reg.count;

endmodule : ppf_pin_sampler

// *** ppf_interval_timer.sv ***
// ppf_interval_timer: one-second prescaler and interval counter.
// assumes target is already limited to the legal interval range.
`timescale 1ns/100ps
module ppf_interval_timer #(
  parameter int unsigned CYCLES_PER_SEC = ppf_pkg::CYCLES_PER_SEC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic enable,
  input wire logic [16:0] target,
  output logic tick
);

  typedef struct packed {
    logic [31:0] pre;
    logic [16:0] sec;
    logic tick;
  } ppf_tmr_s;

  ppf_tmr_s r_reg;
  ppf_tmr_s r_next;

  always_comb
  begin
    r_next = r_reg;
    r_next.tick = 1'b0;
    if (!enable)
    begin
      r_next.pre = 32'h0000_0000;
      r_next.sec = 17'h00000;
    end
    else if (r_reg.pre == 32'(CYCLES_PER_SEC - 1))
    begin
      r_next.pre = 32'h0000_0000;
      if (r_reg.sec + 17'h00001 >= target)
      begin
        r_next.sec = 17'h00000;
        r_next.tick = 1'b1;
      end
      else
      begin
        r_next.sec = r_reg.sec + 17'h00001;
      end
    end
    else
    begin
      r_next.pre = r_reg.pre + 32'h0000_0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign tick = r_reg.tick;

endmodule : ppf_interval_timer

// *** ppf_framer.sv ***
// ppf_framer: periodic payload framer with AHB-Lite register slave.
// assumes one AHB-Lite master, word accesses, and a transport that takes
// bytes on tx_valid/tx_ready; neighbour table answers nb_sel in-cycle.
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
// Operation
// - tag byte opens every package
// - package goes to configured destination address
// - periodic, interval 10 s to 24 h
// - per-pin mode, digital input after reset
// - report mask selects pins in package
// - per-pin pull, one shared up/down choice
// - single counter pin counts falling edges
// - four converter channels, input selectable
// - converter reference selectable per channel
// - converter width 7, 9, 10, 12
// - pin package field order fixed
// - edge mask flags falling edges only
// - level byte holds pin levels
// - converter result left-aligned two's complement
// - sensor temperature 14-bit left-aligned
// - humidity 12-bit left-aligned after temperature
// - neighbour report up to five entries
// - more than five neighbours rotate
// - strength byte is magnitude of dBm
module ppf_framer #(
  parameter int unsigned CYCLES_PER_SEC = ppf_pkg::CYCLES_PER_SEC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pull_en,
  output logic pin_pull_up,
  output logic [7:0] pin_analog_en,
  output logic [31:0] conv_cfg,
  input wire logic [11:0] conv_result_1,
  input wire logic [11:0] conv_result_2,
  input wire logic [11:0] conv_result_3,
  input wire logic [11:0] conv_result_4,
  input wire logic [13:0] sensor_temp,
  input wire logic [11:0] sensor_hum,
  input wire logic [7:0] nb_count,
  output logic [7:0] nb_sel,
  input wire logic [15:0] nb_addr,
  input wire logic signed [7:0] nb_level,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic [15:0] dest_node_addr,
  input wire logic tx_ready
);

  typedef struct packed {
    logic en;
    logic [1:0] app;
    logic [1:0] unit;
    logic [15:0] ival;
    logic [7:0] tag;
    logic [15:0] dest;
    logic [15:0] mode;
    logic [7:0] rmask;
    logic [7:0] pull;
    logic pull_up;
    logic [7:0] dout;
    logic cnt_en;
    logic [2:0] cnt_pin;
    logic [31:0] conv;
    logic ph_wr;
    logic [7:0] ph_addr;
    logic [31:0] hrdata;
    logic hready;
    ppf_pkg::ppf_state_e st;
    logic [3:0] idx;
    logic [3:0] len;
    logic [2:0] fi;
    logic [2:0] n_ent;
    logic [7:0] base;
    logic [7:0] rot;
    logic [1:0] c_app;
    logic [7:0] c_tag;
    logic [7:0] c_edge;
    logic [7:0] c_lvl;
    logic [15:0] c_cnt;
    logic [63:0] c_conv;
    logic [15:0] c_temp;
    logic [15:0] c_hum;
    logic [119:0] nb;
    logic pending;
    logic [7:0] pkts;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_last;
    logic [15:0] tx_dest;
    logic [7:0] nb_sel;
    logic [7:0] pin_oe;
    logic [7:0] pin_pull_en;
    logic [7:0] pin_analog_en;
  } ppf_frm_s;

  ppf_frm_s r_reg;
  ppf_frm_s r_next;
  logic [7:0] s_level;
  logic [7:0] s_edges;
  logic [15:0] s_count;
  logic tick;
  logic take;
  logic cnt_live;
  logic [16:0] ival_s;

  // register read view
  function automatic logic [31:0] reg_read(input ppf_frm_s s, input logic [7:0] a,
                                           input logic [7:0] lv, input logic [7:0] ed,
                                           input logic [15:0] cn);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      ppf_pkg::OFF_CTRL: d = {27'h0, s.unit, s.app, s.en};
      ppf_pkg::OFF_INTERVAL: d = {16'h0000, s.ival};
      ppf_pkg::OFF_TAG: d = {24'h000000, s.tag};
      ppf_pkg::OFF_DEST: d = {16'h0000, s.dest};
      ppf_pkg::OFF_PIN_MODE: d = {16'h0000, s.mode};
      ppf_pkg::OFF_PIN_CFG: d = {s.dout, 7'h00, s.pull_up, s.pull, s.rmask};
      ppf_pkg::OFF_COUNTER: d = {28'h0000000, s.cnt_en, s.cnt_pin};
      ppf_pkg::OFF_CONV_CFG: d = s.conv;
      ppf_pkg::OFF_STATUS: d = {cn, s.pkts, 6'h00, s.pending, s.st != ppf_pkg::ST_IDLE};
      ppf_pkg::OFF_SNAPSHOT: d = {16'h0000, ed, lv};
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction : reg_read

  // left-align a converter result by configured width
  function automatic logic [15:0] conv_align(input logic [11:0] v, input logic [1:0] res);
    logic [15:0] w;
    w = {v, 4'h0};
    unique case (res)
      2'h0: w = w << 5;
      2'h1: w = w << 3;
      2'h2: w = w << 2;
      2'h3: w = w;
    endcase
    return w;
  endfunction : conv_align

  // neighbour table index with wrap
  function automatic logic [7:0] nb_index(input logic [7:0] b, input logic [2:0] i,
                                          input logic [7:0] cnt);
    logic [8:0] s;
    s = {1'b0, b} + {6'h00, i};
    if (s >= {1'b0, cnt})
    begin
      s = s - {1'b0, cnt};
    end
    return s[7:0];
  endfunction : nb_index

  // payload byte at position i
  function automatic logic [7:0] pkt_byte(input ppf_frm_s s, input logic [3:0] i);
    logic [7:0] d;
    int k;
    d = 8'h00;
    k = 0;
    if (i == 4'h0)
    begin
      d = s.c_tag;
    end
    else
    begin
      unique case (s.c_app)
        ppf_pkg::APP_PINS:
        begin
          unique case (i)
            4'h1: d = s.c_edge;
            4'h2: d = s.c_lvl;
            4'h3: d = s.c_cnt[15:8];
            4'h4: d = s.c_cnt[7:0];
            default: d = s.c_conv[(12 - int'(i)) * 8 +: 8];
          endcase
        end
        ppf_pkg::APP_SENSOR:
        begin
          unique case (i)
            4'h1: d = s.c_temp[15:8];
            4'h2: d = s.c_temp[7:0];
            4'h3: d = s.c_hum[15:8];
            default: d = s.c_hum[7:0];
          endcase
        end
        default:
        begin
          k = int'(i) - 1;
          d = s.nb[(k / 3) * 24 + (2 - (k % 3)) * 8 +: 8];
        end
      endcase
    end
    return d;
  endfunction : pkt_byte

  ppf_pin_sampler u_sampler (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(pin_in),
    .cnt_en(cnt_live),
    .cnt_pin(r_reg.cnt_pin),
    .clear(take),
    .level(s_level),
    .edges(s_edges),
    .count(s_count)
  );

  ppf_interval_timer #(
    .CYCLES_PER_SEC(CYCLES_PER_SEC)
  ) u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(r_reg.en),
    .target(ival_s),
    .tick(tick)
  );

  // counter pin must be a digital input
  assign cnt_live = r_reg.cnt_en && r_reg.mode[{r_reg.cnt_pin, 1'b0} +: 2] == ppf_pkg::PIN_DIN;
  assign take = r_reg.en && r_reg.pending && r_reg.st == ppf_pkg::ST_IDLE;

  // interval in seconds, held to the legal range
  always_comb
  begin
    logic [32:0] p;
    p = 33'h0;
    unique case (r_reg.unit)
      ppf_pkg::UNIT_MIN: p = r_reg.ival * ppf_pkg::SEC_PER_MIN;
      ppf_pkg::UNIT_HOUR: p = r_reg.ival * ppf_pkg::SEC_PER_HOUR;
      default: p = {17'h0, r_reg.ival};
    endcase
    if (p < {16'h0, ppf_pkg::MIN_INTERVAL_S})
    begin
      ival_s = ppf_pkg::MIN_INTERVAL_S;
    end
    else if (p > {16'h0, ppf_pkg::MAX_INTERVAL_S})
    begin
      ival_s = ppf_pkg::MAX_INTERVAL_S;
    end
    else
    begin
      ival_s = p[16:0];
    end
  end

  always_comb
  begin
    logic [7:0] n_sat;
    logic [7:0] b_used;
    r_next = r_reg;
    n_sat = (nb_count > ppf_pkg::MAX_NEIGH) ? ppf_pkg::MAX_NEIGH : nb_count;
    b_used = (r_reg.rot >= nb_count) ? 8'h00 : r_reg.rot;
    // data phase of a write
    if (r_reg.ph_wr)
    begin
      unique case (r_reg.ph_addr)
        ppf_pkg::OFF_CTRL:
        begin
          r_next.en = hwdata[ppf_pkg::CTRL_EN_BIT];
          r_next.app = hwdata[ppf_pkg::CTRL_APP_LSB +: 2];
          r_next.unit = hwdata[ppf_pkg::CTRL_UNIT_LSB +: 2];
        end
        ppf_pkg::OFF_INTERVAL: r_next.ival = hwdata[15:0];
        ppf_pkg::OFF_TAG: r_next.tag = hwdata[7:0];
        ppf_pkg::OFF_DEST: r_next.dest = hwdata[15:0];
        ppf_pkg::OFF_PIN_MODE: r_next.mode = hwdata[15:0];
        ppf_pkg::OFF_PIN_CFG:
        begin
          r_next.rmask = hwdata[ppf_pkg::CFG_MASK_LSB +: 8];
          r_next.pull = hwdata[ppf_pkg::CFG_PULL_LSB +: 8];
          r_next.pull_up = hwdata[ppf_pkg::CFG_PULLUP_BIT];
          r_next.dout = hwdata[ppf_pkg::CFG_DOUT_LSB +: 8];
        end
        ppf_pkg::OFF_COUNTER:
        begin
          r_next.cnt_en = hwdata[ppf_pkg::CNT_EN_BIT];
          r_next.cnt_pin = hwdata[2:0];
        end
        ppf_pkg::OFF_CONV_CFG: r_next.conv = hwdata;
        default: r_next.conv = r_next.conv;
      endcase
    end
    r_next.ph_wr = hsel && htrans[1] && hready && hwrite;
    r_next.ph_addr = {haddr[7:2], 2'b00};
    r_next.hready = 1'b1;
    // tick beats the take
    r_next.pending = r_reg.en && ((r_reg.pending && !take) || tick);
    unique case (r_reg.st)
      ppf_pkg::ST_IDLE:
      begin
        if (take)
        begin
          r_next.c_app = r_reg.app;
          r_next.c_tag = r_reg.tag;
          r_next.tx_dest = r_reg.dest;
          r_next.c_edge = s_edges & r_reg.rmask;
          r_next.c_lvl = s_level & r_reg.rmask;
          r_next.c_cnt = s_count;
          r_next.c_conv = {conv_align(conv_result_1, r_reg.conv[6 +: 2]),
                           conv_align(conv_result_2, r_reg.conv[14 +: 2]),
                           conv_align(conv_result_3, r_reg.conv[22 +: 2]),
                           conv_align(conv_result_4, r_reg.conv[30 +: 2])};
          r_next.c_temp = {sensor_temp, 2'b00};
          r_next.c_hum = {sensor_hum, 4'h0};
          r_next.n_ent = n_sat[2:0];
          r_next.base = b_used;
          // advance by five only when the list is longer
          if (nb_count > ppf_pkg::MAX_NEIGH)
          begin
            r_next.rot = nb_index(b_used, 3'h5, nb_count);
          end
          else
          begin
            r_next.rot = 8'h00;
          end
          r_next.idx = 4'h0;
          r_next.fi = 3'h0;
          r_next.nb_sel = b_used;
          if (r_reg.app == ppf_pkg::APP_PINS)
          begin
            r_next.len = ppf_pkg::LEN_PINS;
          end
          else if (r_reg.app == ppf_pkg::APP_SENSOR)
          begin
            r_next.len = ppf_pkg::LEN_SENSOR;
          end
          else
          begin
            r_next.len = 4'h1 + {1'b0, n_sat[2:0]} * 4'h3;
          end
          if (r_reg.app == ppf_pkg::APP_NEIGH && n_sat != 8'h00)
          begin
            r_next.st = ppf_pkg::ST_FETCH;
          end
          else
          begin
            r_next.st = ppf_pkg::ST_SEND;
            r_next.tx_valid = 1'b1;
            r_next.tx_data = r_reg.tag;
            r_next.tx_last = (r_next.len == 4'h1);
          end
        end
      end
      ppf_pkg::ST_FETCH:
      begin
        r_next.nb[int'(r_reg.fi) * 24 +: 24] = {nb_addr, 8'(-nb_level)};
        r_next.fi = r_reg.fi + 3'h1;
        r_next.nb_sel = nb_index(r_reg.base, r_reg.fi + 3'h1, nb_count);
        if (r_reg.fi + 3'h1 == r_reg.n_ent)
        begin
          r_next.st = ppf_pkg::ST_SEND;
          r_next.tx_valid = 1'b1;
          r_next.tx_data = r_reg.c_tag;
          r_next.tx_last = 1'b0;
        end
      end
      ppf_pkg::ST_SEND:
      begin
        if (tx_ready)
        begin
          if (r_reg.tx_last)
          begin
            r_next.st = ppf_pkg::ST_IDLE;
            r_next.tx_valid = 1'b0;
            r_next.tx_last = 1'b0;
            r_next.pkts = r_reg.pkts + 8'h01;
          end
          else
          begin
            r_next.idx = r_reg.idx + 4'h1;
            r_next.tx_data = pkt_byte(r_reg, r_reg.idx + 4'h1);
            r_next.tx_last = (r_reg.idx + 4'h2 == r_reg.len);
          end
        end
      end
      default:
      begin
        r_next.st = ppf_pkg::ST_IDLE;
        r_next.tx_valid = 1'b0;
      end
    endcase
    // pin drivers
    for (int i = 0; i < 8; i++)
    begin
      r_next.pin_oe[i] = r_next.mode[2 * i +: 2] == ppf_pkg::PIN_DOUT;
      r_next.pin_analog_en[i] = r_next.mode[2 * i +: 2] == ppf_pkg::PIN_AIN;
      r_next.pin_pull_en[i] = r_next.pull[i] && r_next.mode[2 * i +: 2] == ppf_pkg::PIN_DIN;
    end
    // read sees this cycle's write
    r_next.hrdata = (hsel && htrans[1] && hready && !hwrite)
                    ? reg_read(r_next, {haddr[7:2], 2'b00}, s_level, s_edges, s_count)
                    : r_reg.hrdata;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r_reg <= '0;
      r_reg.ival <= ppf_pkg::INTERVAL_RST;
      r_reg.tag <= ppf_pkg::TAG_RST;
      r_reg.dest <= ppf_pkg::DEST_RST;
      r_reg.mode <= ppf_pkg::PIN_MODE_RST;
      r_reg.conv <= ppf_pkg::CONV_CFG_RST;
      r_reg.hready <= 1'b1;
      r_reg.st <= ppf_pkg::ST_IDLE;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign hreadyout = r_reg.hready;
  assign hresp = 1'b0;
  assign hrdata = r_reg.hrdata;
  assign pin_out = r_reg.dout;
  assign pin_oe = r_reg.pin_oe;
  assign pin_pull_en = r_reg.pin_pull_en;
  assign pin_pull_up = r_reg.pull_up;
  assign pin_analog_en = r_reg.pin_analog_en;
  assign conv_cfg = r_reg.conv;
  assign nb_sel = r_reg.nb_sel;
  assign tx_valid = r_reg.tx_valid;
  assign tx_data = r_reg.tx_data;
  assign tx_last = r_reg.tx_last;
  assign dest_node_addr = r_reg.tx_dest;

endmodule : ppf_framer

// *** ppf_framer_properties.sv ***
// ppf_framer_properties: port-level checks of the payload framer.
// assumes it is bound into ppf_framer and sees only its ports.
`timescale 1ns/100ps
module ppf_framer_properties #(
  parameter int unsigned CYCLES_PER_SEC = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_analog_en,
  input wire logic [7:0] pin_pull_en,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic [15:0] dest_node_addr,
  input wire logic tx_ready
);
  logic [4:0] nb_reg;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // bytes accepted so far in the current package
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      nb_reg <= 5'h00;
    else if (tx_valid && tx_ready)
      nb_reg <= tx_last ? 5'h00 : nb_reg + 5'h01;
  chk_resp_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus slave not ready or not okay");
  chk_byte_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("byte changed before acceptance");
  chk_next_byte: assert property (tx_valid && tx_ready && !tx_last |=> tx_valid)
    else $error("gap inside package");
  chk_dest_hold: assert property (tx_valid && !(tx_ready && tx_last) |=> $stable(dest_node_addr))
    else $error("destination changed inside package");
  chk_pin_excl: assert property ((pin_oe & pin_analog_en) == 8'h00)
    else $error("pin both output and analogue");
  chk_pull_din: assert property ((pin_pull_en & (pin_oe | pin_analog_en)) == 8'h00)
    else $error("pull on a non-input pin");
  chk_pkt_gap: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
    else $error("valid held after last byte");
  chk_pkt_len: assert property (tx_valid && tx_ready && tx_last |-> nb_reg inside {0, 3, 4, 6, 9, 12, 15})
    else $error("package length illegal");
endmodule : ppf_framer_properties

bind ppf_framer ppf_framer_properties #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) chk_u (
  .hclk(hclk),
  .hresetn(hresetn),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .pin_oe(pin_oe),
  .pin_analog_en(pin_analog_en),
  .pin_pull_en(pin_pull_en),
  .tx_valid(tx_valid),
  .tx_data(tx_data),
  .tx_last(tx_last),
  .dest_node_addr(dest_node_addr),
  .tx_ready(tx_ready)
);

// *** ppf_transport_model.sv ***
// ppf_transport_model: byte sink of the transport plus neighbour table.
// assumes it shares hclk and hresetn with the framer.
`timescale 1ns/100ps
module ppf_transport_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic [15:0] dest_node_addr,
  output logic tx_ready,
  input wire logic [7:0] nb_sel,
  output logic [15:0] nb_addr,
  output logic signed [7:0] nb_level
);
  logic [7:0] q[$];
  logic [15:0] last_dest;
  int pkts;
  logic [1:0] ph;
  // stalls one cycle in four
  assign tx_ready = (ph != 2'h0);
  assign nb_addr = {8'hA0, nb_sel};
  // level of entry i is -(40+i) dBm
  assign nb_level = 8'h00 - (8'h28 + nb_sel);
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ph <= 2'h0;
      pkts <= 0;
    end
    else
    begin
      ph <= ph + 2'h1;
      if (tx_valid && tx_ready)
      begin
        q.push_back(tx_data);
        last_dest <= dest_node_addr;
        if (tx_last)
          pkts <= pkts + 1;
      end
    end
endmodule : ppf_transport_model

// *** tb_top.sv ***
// tb_top: register, pin, sensor and neighbour package tests of the framer.
// assumes a shortened second (CPS cycles) and the transport model.
`timescale 1ns/100ps
module tb_top;
  localparam int CPS = 4;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, conv_cfg, rd;
  logic hreadyout, hresp, pin_pull_up, tx_valid, tx_last, tx_ready;
  logic [7:0] pin_in = 8'hEF, nb_count = 8'h00, pin_out, pin_oe, pin_pull_en, pin_analog_en, nb_sel, tx_data;
  logic [11:0] conv_result_1 = 12'h045, conv_result_2 = 12'h1A3, conv_result_3 = 12'h2F0, conv_result_4 = 12'h9C1;
  logic [13:0] sensor_temp = 14'h2ABC;
  logic [11:0] sensor_hum = 12'hBCD;
  logic [15:0] nb_addr, dest_node_addr;
  logic signed [7:0] nb_level;
  logic [7:0] e[$];
  int failures = 0, n_tests = 0, cyc = 0, t0 = 0;

  ppf_framer #(.CYCLES_PER_SEC(CPS)) dut_u (.hready(hreadyout), .hsize(3'h2), .*);
  ppf_transport_model m (.*);

  initial forever #5 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;

  task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x)
    begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, x, g);
    end
  endtask : cmp

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic rchk(input logic [7:0] a, input logic [31:0] x, input string n);
    ahb(1'b0, a, 32'h0);
    cmp(n, x, rd);
  endtask : rchk

  task automatic run(input logic [7:0] c, input logic [15:0] v);
    ahb(1'b1, ppf_pkg::OFF_CTRL, 32'h0);
    ahb(1'b1, ppf_pkg::OFF_INTERVAL, {16'h0, v});
    ahb(1'b1, ppf_pkg::OFF_CTRL, {24'h0, c});
    t0 = cyc;
  endtask : run

  task automatic tchk(input int x);
    while (tx_valid !== 1'b1 && cyc - t0 < x + 40) @(posedge hclk);
    cmp("period", 32'h1, {31'h0, (cyc - t0 >= x) && (cyc - t0 <= x + 6)});
  endtask : tchk

  task automatic wpkt(input int k);
    for (int i = 0; i < 20000 && m.pkts < k; i++) @(posedge hclk);
    #1;
  endtask : wpkt

  task automatic pchk(input string n);
    cmp({n, " len"}, e.size(), m.q.size());
    foreach (e[i]) cmp(n, e[i], m.q[i]);
    m.q.delete();
  endtask : pchk

  // widths 7, 9, 10, 12 left-aligned in two bytes
  task automatic addcv;
    logic [15:0] t[4];
    t = '{{conv_result_1, 4'h0} << (12 - 7), {conv_result_2, 4'h0} << (12 - 9),
          {conv_result_3, 4'h0} << (12 - 10), {conv_result_4, 4'h0}};
    foreach (t[i])
    begin
      e.push_back(t[i][15:8]);
      e.push_back(t[i][7:0]);
    end
  endtask : addcv

  task automatic nexp(input int b, input int n, input int c);
    e = {8'h5C};
    for (int i = 0; i < n; i++)
    begin
      e.push_back(8'hA0);
      e.push_back(8'((b + i) % c));
      e.push_back(8'h28 + 8'((b + i) % c));
    end
  endtask : nexp

  task automatic final_report;
    $display("checks %0d errors %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(ppf_pkg::OFF_INTERVAL, {16'h0, ppf_pkg::INTERVAL_RST}, "interval");
    cmp("oe rst", 8'h00, pin_oe);
    ahb(1'b1, 8'h28, 32'hFFFF_FFFF);
    rchk(8'h28, 32'h0, "unmapped");
    ahb(1'b1, ppf_pkg::OFF_TAG, 32'h5C);
    ahb(1'b1, ppf_pkg::OFF_DEST, 32'h1234);
    ahb(1'b1, ppf_pkg::OFF_PIN_MODE, 32'h6000);
    ahb(1'b1, ppf_pkg::OFF_PIN_CFG, 32'h8001_0F3F);
    ahb(1'b1, ppf_pkg::OFF_COUNTER, 32'h9);
    ahb(1'b1, ppf_pkg::OFF_CONV_CFG, 32'hF4A3_5201);
    rchk(ppf_pkg::OFF_TAG, 32'h5C, "tag");
    cmp("oe", 8'h80, pin_oe);
    cmp("analog", 8'h40, pin_analog_en);
    cmp("dout", 8'h80, pin_out);
    cmp("pull", 8'h0F, pin_pull_en);
    cmp("pullup", 1'b1, pin_pull_up);
    cmp("conv", 32'hF4A3_5201, conv_cfg);
    // interval 3 s is raised to the 10 s floor
    run(8'h01, 16'h3);
    repeat (3)
    begin
      @(posedge hclk) pin_in <= pin_in & 8'hFD;
      repeat (2) @(posedge hclk);
      pin_in <= pin_in | 8'h02;
      repeat (2) @(posedge hclk);
    end
    pin_in <= 8'hB7;
    tchk(10 * CPS);
    wpkt(1);
    e = {8'h5C, 8'h0A, 8'h37, 8'h00, 8'h03};
    addcv;
    pchk("pins");
    cmp("dest", 16'h1234, m.last_dest);
    wpkt(2);
    e = {8'h5C, 8'h00, 8'h37, 8'h00, 8'h00};
    addcv;
    pchk("pins2");
    rchk(ppf_pkg::OFF_STATUS, 32'h0000_0200, "status");
    run(8'h0B, 16'h1);
    tchk(60 * CPS);
    wpkt(3);
    e = {8'h5C, 8'hAA, 8'hF0, 8'hBC, 8'hD0};
    pchk("sensor");
    nb_count <= 8'h07;
    run(8'h15, 16'h1);
    // neighbour fetch adds one cycle per entry
    tchk(3600 * CPS + 5);
    wpkt(4);
    nexp(0, 5, 7);
    pchk("nb1");
    wpkt(5);
    nexp(5, 5, 7);
    pchk("nb2");
    nb_count <= 8'h02;
    run(8'h05, 16'hA);
    tchk(10 * CPS + 2);
    wpkt(6);
    nexp(0, 2, 2);
    pchk("nb3");
    nb_count <= 8'h00;
    run(8'h05, 16'hA);
    tchk(10 * CPS);
    wpkt(7);
    e = {8'h5C};
    pchk("nb0");
    final_report;
  end

  initial
  begin
    #600000;
    failures++;
    final_report;
  end
endmodule : tb_top
